// [cmp_regs.svh]
`ifndef CMP_REGS_SVH
`define CMP_REGS_SVH

// ==========================================================================
// Register byte offsets on the AXI4-Lite slave
// ==========================================================================
`define OFS_SPECIAL_IO 8'h00
`define OFS_CTRL_STATUS 8'h04
`define OFS_IRQ_STATUS 8'h08
`define OFS_IRQ_MASK 8'h0c

// ==========================================================================
// Field positions in special_function_io
// ==========================================================================
`define SFIO_MUX_EN_BIT 3
`define SFIO_RSVD_BIT 4

// ==========================================================================
// Field positions in comparator_ctrl_status
// ==========================================================================
`define CS_POWER_OFF_BIT 7
`define CS_BANDGAP_BIT 6
`define CS_OUTPUT_BIT 5
`define CS_FLAG_BIT 4
`define CS_IRQ_EN_BIT 3
`define CS_CAPTURE_BIT 2
`define CS_MODE_HI_BIT 1
`define CS_MODE_LO_BIT 0

// ==========================================================================
// Field positions in irq status and irq mask
// ==========================================================================
`define IRQ_MATCH_BIT 0
`define IRQ_RISE_BIT 1
`define IRQ_FALL_BIT 2
`define IRQ_WIDTH 3

// ==========================================================================
// Reset values and interrupt mode codes
// ==========================================================================
`define RST_SPECIAL_IO 8'h00
`define RST_CTRL_BITS 8'h00
`define RST_IRQ_MASK 3'h0
`define MODE_TOGGLE 2'h0
`define MODE_RESERVED 2'h1
`define MODE_FALL 2'h2
`define MODE_RISE 2'h3

// ==========================================================================
// Bus response codes
// ==========================================================================
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [cmp_pkg.sv]
package cmp_pkg;

   // ========================================================================
   // Shared types
   // ========================================================================
   // Two-bit comparator interrupt mode field
   typedef logic [1:0] irq_mode_type;
   // Byte wide register image
   typedef logic [7:0] byte_type;
   // Event vector for the interrupt status and mask registers
   typedef logic [2:0] irq_vec_type;

endpackage : cmp_pkg

// [cmp_sync_edge.sv]
`timescale 1ns/100ps

// ==========================================================================
// Two-stage synchroniser with edge detection on the settled level
// ==========================================================================
module cmp_sync_edge (
   input wire logic clk,
   input wire logic rst,
   input wire logic din,
   output logic level_q,
   output logic rise,
   output logic fall
);

   logic meta_q; // First stage, read only by the second stage
   logic prev_q; // Settled level one clock earlier

   // Synchroniser chain; the analog result is asynchronous to the clock
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= 1'b0;
         level_q <= 1'b0;
      end else begin
         meta_q <= din;
         level_q <= meta_q;
      end
   end

   // History register for edge detection
   always_ff @(posedge clk) begin
      if (rst) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= level_q;
      end
   end

   // Edges compare the settled level with its previous value
   assign rise = level_q & ~prev_q;
   assign fall = ~level_q & prev_q;

endmodule : cmp_sync_edge

// [cmp_ctrl.sv]
`timescale 1ns/100ps
`include "cmp_regs.svh"

module cmp_ctrl #(
   parameter int ADDR_W = 8
) (
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   // AXI4-Lite write address channel
   input wire logic [ADDR_W-1:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   // AXI4-Lite write data channel
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   // AXI4-Lite write response channel
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   // AXI4-Lite read address channel
   input wire logic [ADDR_W-1:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   // AXI4-Lite read data channel
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   // Analog comparator core
   input wire logic RAW_COMPARE,
   output logic POWER_OFF,
   output logic BANDGAP_SELECT,
   output logic NEG_MUX_ACTIVE,
   output logic [2:0] NEG_CHANNEL,
   // Converter state that steers the negative input
   input wire logic CONVERTER_ENABLE,
   input wire logic [2:0] CHANNEL_SELECT,
   // Processor interrupt interface
   input wire logic GLOBAL_IRQ_ENABLE,
   input wire logic IRQ_VECTOR_ACK,
   output logic CMP_IRQ_REQ,
   // Timer input capture front end
   output logic CAPTURE_ROUTE,
   output logic CAPTURE_INPUT,
   // Settled comparator level and summary interrupt
   output logic COMPARATOR_OUT,
   output logic IRQ
);

   // ========================================================================
   // Helper functions
   // ========================================================================

   // True when an address selects the given register word
   function automatic logic hits(input logic [ADDR_W-1:0] addr,
                                 input logic [7:0] ofs);
      logic [7:0] a8;
      a8 = 8'(addr);
      hits = (a8[7:2] == ofs[7:2]);
   endfunction : hits
   // True when any register word is selected
   function automatic logic mapped(input logic [ADDR_W-1:0] addr);
      mapped = hits(addr, `OFS_SPECIAL_IO) | hits(addr, `OFS_CTRL_STATUS) |
               hits(addr, `OFS_IRQ_STATUS) | hits(addr, `OFS_IRQ_MASK);
   endfunction : mapped
   // Decode the interrupt mode against the detected edges
   function automatic logic mode_match(input cmp_pkg::irq_mode_type mode,
                                       input logic rise,
                                       input logic fall);
      unique case (mode)
         `MODE_TOGGLE: mode_match = rise | fall;
         `MODE_RESERVED: mode_match = 1'b0;
         `MODE_FALL: mode_match = fall;
         `MODE_RISE: mode_match = rise;
      endcase
   endfunction : mode_match

   // ========================================================================
   // Register state
   // ========================================================================
   cmp_pkg::byte_type special_io_q; // Bit 3 mux enable, bit 4 reserved
   logic power_off_q; // Comparator power down
   logic bandgap_q; // Positive input from the bandgap
   logic flag_q; // Comparator interrupt flag
   logic irq_en_q; // Comparator interrupt enable
   logic capture_q; // Route to timer input capture
   cmp_pkg::irq_mode_type mode_q; // Interrupt mode select
   cmp_pkg::irq_vec_type irq_status_q; // Sticky events, cleared on read
   cmp_pkg::irq_vec_type irq_mask_q; // Enables for the summary line
   logic aw_held_q; // Write address captured
   logic [ADDR_W-1:0] aw_addr_q; // Captured write address
   logic w_held_q; // Write data captured
   logic [31:0] w_data_q; // Captured write data
   logic [3:0] w_strb_q; // Captured byte enables
   logic bvalid_q; // Write response pending
   logic [1:0] bresp_q; // Write response code
   logic rvalid_q; // Read data pending
   logic [31:0] rdata_q; // Read data word
   logic [1:0] rresp_q; // Read response code
   logic aw_take; // Write address handshake
   logic w_take; // Write data handshake
   logic wr_do; // Both halves present, write performed now
   logic lane0; // Low byte enabled on the performed write
   logic wr_ctrl; // Write to comparator_ctrl_status
   logic wr_special; // Write to special_function_io
   logic wr_mask; // Write to irq mask
   logic ar_take; // Read address handshake
   logic rd_status; // Read of irq status, clears it
   logic cmp_level; // Synchronised comparator result
   logic cmp_rise; // Rising edge of the settled result
   logic cmp_fall; // Falling edge of the settled result
   logic raw_gated; // Raw result forced low while powered off
   logic match; // Event matches the selected mode
   cmp_pkg::irq_vec_type events; // Event vector for status bits
   // Accept each channel only while no response is pending
   assign AWREADY = ~aw_held_q & ~bvalid_q;
   assign WREADY = ~w_held_q & ~bvalid_q;
   assign ARREADY = ~rvalid_q;
   assign aw_take = AWVALID & AWREADY;
   assign w_take = WVALID & WREADY;
   assign ar_take = ARVALID & ARREADY;
   // Writes complete one edge after both halves are held
   assign wr_do = aw_held_q & w_held_q & ~bvalid_q;
   assign lane0 = w_strb_q[0];
   assign wr_ctrl = wr_do & lane0 & hits(aw_addr_q, `OFS_CTRL_STATUS);
   assign wr_special = wr_do & lane0 & hits(aw_addr_q, `OFS_SPECIAL_IO);
   assign wr_mask = wr_do & lane0 & hits(aw_addr_q, `OFS_IRQ_MASK);
   assign rd_status = ar_take & hits(ARADDR, `OFS_IRQ_STATUS);
   assign BVALID = bvalid_q;
   assign BRESP = bresp_q;
   assign RVALID = rvalid_q;
   assign RDATA = rdata_q;
   assign RRESP = rresp_q;

   // ========================================================================
   // Write channel capture
   // ========================================================================
   // Address and data are taken in either order and held until used
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         aw_held_q <= 1'b0;
         aw_addr_q <= '0;
      end else if (aw_take) begin
         aw_held_q <= 1'b1;
         aw_addr_q <= AWADDR;
      end else if (wr_do) begin
         aw_held_q <= 1'b0;
      end
   end
   // Data half of the write
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         w_held_q <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end else if (w_take) begin
         w_held_q <= 1'b1;
         w_data_q <= WDATA;
         w_strb_q <= WSTRB;
      end else if (wr_do) begin
         w_held_q <= 1'b0;
      end
   end
   // Write response; unmapped words answer with a slave error
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
      end else if (wr_do) begin
         bvalid_q <= 1'b1;
         bresp_q <= mapped(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (BREADY) begin
         bvalid_q <= 1'b0;
      end
   end

   // ========================================================================
   // Read channel
   // ========================================================================
   // Data are sampled at the address handshake, so a read of the status
   // word returns the events that its own clear removes
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= `RESP_OKAY;
      end else if (ar_take) begin
         rvalid_q <= 1'b1;
         rresp_q <= mapped(ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
         if (hits(ARADDR, `OFS_SPECIAL_IO)) begin
            rdata_q <= {24'h000000, special_io_q};
         end else if (hits(ARADDR, `OFS_CTRL_STATUS)) begin
            rdata_q <= {24'h000000, power_off_q, bandgap_q, cmp_level,
                        flag_q, irq_en_q, capture_q, mode_q};
         end else if (hits(ARADDR, `OFS_IRQ_STATUS)) begin
            rdata_q <= {29'h00000000, irq_status_q};
         end else if (hits(ARADDR, `OFS_IRQ_MASK)) begin
            rdata_q <= {29'h00000000, irq_mask_q};
         end else begin
            // Unmapped words read as zero
            rdata_q <= '0;
         end
      end else if (RREADY) begin
         rvalid_q <= 1'b0;
      end
   end

   // ========================================================================
   // Special function register
   // ========================================================================
   // Only the mux enable is used here; the other bits are plain storage
   // owned by neighbouring blocks, and the reserved bit stays zero
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         special_io_q <= `RST_SPECIAL_IO;
      end else if (wr_special) begin
         special_io_q <= w_data_q[7:0];
         special_io_q[`SFIO_RSVD_BIT] <= 1'b0;
      end
   end

   // ========================================================================
   // Comparator control bits
   // ========================================================================
   // Power down acts whenever written; changing it or the mode with the
   // interrupt enabled may raise an event, which software must avoid
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         {power_off_q, bandgap_q} <= 2'h0;
         {irq_en_q, capture_q} <= 2'h0;
         mode_q <= `MODE_TOGGLE;
      end else if (wr_ctrl) begin
         power_off_q <= w_data_q[`CS_POWER_OFF_BIT];
         bandgap_q <= w_data_q[`CS_BANDGAP_BIT];
         irq_en_q <= w_data_q[`CS_IRQ_EN_BIT];
         capture_q <= w_data_q[`CS_CAPTURE_BIT];
         mode_q <= w_data_q[`CS_MODE_HI_BIT:`CS_MODE_LO_BIT];
      end
   end

   // ========================================================================
   // Analog selection outputs
   // ========================================================================
   // Registered so the analog muxes never see decode glitches
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         POWER_OFF <= 1'b0;
         BANDGAP_SELECT <= 1'b0;
         NEG_MUX_ACTIVE <= 1'b0;
         NEG_CHANNEL <= 3'h0;
      end else begin
         POWER_OFF <= power_off_q;
         BANDGAP_SELECT <= bandgap_q;
         if (special_io_q[`SFIO_MUX_EN_BIT] & ~CONVERTER_ENABLE) begin
            // Converter channel replaces the negative pin
            NEG_MUX_ACTIVE <= 1'b1;
            NEG_CHANNEL <= CHANNEL_SELECT;
         end else begin
            // Dedicated negative pin, channel field ignored
            NEG_MUX_ACTIVE <= 1'b0;
            NEG_CHANNEL <= 3'h0;
         end
      end
   end

   // ========================================================================
   // Result synchronisation and edge detection
   // ========================================================================
   // A powered-down comparator reads low; the change may create an edge
   assign raw_gated = RAW_COMPARE & ~power_off_q;
   cmp_sync_edge sync_u (
      .clk(CORE_CLK),
      .rst(SYS_RST),
      .din(raw_gated),
      .level_q(cmp_level),
      .rise(cmp_rise),
      .fall(cmp_fall)
   );
   assign COMPARATOR_OUT = cmp_level;
   assign match = mode_match(mode_q, cmp_rise, cmp_fall);

   // ========================================================================
   // Comparator interrupt flag
   // ========================================================================
   // A matching event in the clearing cycle wins, so none is lost
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         flag_q <= 1'b0;
      end else if (match) begin
         flag_q <= 1'b1;
      end else if (IRQ_VECTOR_ACK) begin
         flag_q <= 1'b0;
      end else if (wr_ctrl & w_data_q[`CS_FLAG_BIT]) begin
         flag_q <= 1'b0;
      end
   end
   // Request held while flag, local and global enables are all set
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         CMP_IRQ_REQ <= 1'b0;
      end else begin
         CMP_IRQ_REQ <= flag_q & irq_en_q & GLOBAL_IRQ_ENABLE;
      end
   end

   // ========================================================================
   // Timer input capture route
   // ========================================================================
   // The timer's own noise canceler and edge select act on this level;
   // with the route off the capture input is held low
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         CAPTURE_ROUTE <= 1'b0;
         CAPTURE_INPUT <= 1'b0;
      end else begin
         CAPTURE_ROUTE <= capture_q;
         CAPTURE_INPUT <= capture_q & cmp_level;
      end
   end

   // ========================================================================
   // Sticky status, mask and summary interrupt
   // ========================================================================
   assign events = {cmp_fall, cmp_rise, match};
   // Read clears; an event in the same cycle stays set
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         irq_status_q <= '0;
      end else begin
         irq_status_q <= (rd_status ? '0 : irq_status_q) | events;
      end
   end
   // Mask register gates the summary line
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         irq_mask_q <= `RST_IRQ_MASK;
      end else if (wr_mask) begin
         irq_mask_q <= w_data_q[`IRQ_WIDTH-1:0];
      end
   end
   // Level output, registered
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(irq_status_q & irq_mask_q);
      end
   end
endmodule : cmp_ctrl

// [cmp_ctrl_assertions.sv]
`timescale 1ns/100ps
// ==========================================================================
// Port-level checker
// ==========================================================================
module cmp_ctrl_checker (
   input logic CORE_CLK,
   input logic SYS_RST,
   input logic RAW_COMPARE,
   input logic POWER_OFF,
   input logic NEG_MUX_ACTIVE,
   input logic [2:0] NEG_CHANNEL,
   input logic CONVERTER_ENABLE,
   input logic [2:0] CHANNEL_SELECT,
   input logic GLOBAL_IRQ_ENABLE,
   input logic IRQ_VECTOR_ACK,
   input logic CMP_IRQ_REQ,
   input logic CAPTURE_ROUTE,
   input logic CAPTURE_INPUT,
   input logic COMPARATOR_OUT
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);
   // Ack with no new event to set the flag again
   sequence quiet_ack;
      IRQ_VECTOR_ACK && $stable(COMPARATOR_OUT) ##1 $stable(COMPARATOR_OUT);
   endsequence
   a_sync_delay: assert property (
      !$past(SYS_RST) && !$past(SYS_RST, 2) && !POWER_OFF
      && !$past(POWER_OFF) && !$past(POWER_OFF, 2)
      |-> COMPARATOR_OUT == $past(RAW_COMPARE, 2))
      else $error("sync latency wrong");
   a_power_low: assert property (
      POWER_OFF [*3] |-> !COMPARATOR_OUT)
      else $error("powered off output high");
   a_neg_mux: assert property (
      NEG_MUX_ACTIVE |-> !$past(CONVERTER_ENABLE)
      && NEG_CHANNEL == $past(CHANNEL_SELECT))
      else $error("bad channel mux");
   a_neg_idle: assert property (
      !NEG_MUX_ACTIVE |-> NEG_CHANNEL == 3'h0)
      else $error("channel shown when idle");
   a_req_global: assert property (
      CMP_IRQ_REQ |-> $past(GLOBAL_IRQ_ENABLE))
      else $error("request without global enable");
   a_vector_clear: assert property (
      quiet_ack |-> ##1 !CMP_IRQ_REQ)
      else $error("request after ack");
   a_capture_off: assert property (
      !CAPTURE_ROUTE |-> !CAPTURE_INPUT)
      else $error("capture input while off");
   a_capture_rise: assert property (
      $rose(CAPTURE_INPUT) |-> COMPARATOR_OUT || $past(COMPARATOR_OUT))
      else $error("capture rise without level");
endmodule : cmp_ctrl_checker

bind cmp_ctrl cmp_ctrl_checker u_cmp_ctrl_checker (.CORE_CLK(CORE_CLK),
   .SYS_RST(SYS_RST), .RAW_COMPARE(RAW_COMPARE), .POWER_OFF(POWER_OFF),
   .NEG_MUX_ACTIVE(NEG_MUX_ACTIVE), .NEG_CHANNEL(NEG_CHANNEL),
   .CONVERTER_ENABLE(CONVERTER_ENABLE), .CHANNEL_SELECT(CHANNEL_SELECT),
   .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .IRQ_VECTOR_ACK(IRQ_VECTOR_ACK),
   .CMP_IRQ_REQ(CMP_IRQ_REQ), .CAPTURE_ROUTE(CAPTURE_ROUTE),
   .CAPTURE_INPUT(CAPTURE_INPUT), .COMPARATOR_OUT(COMPARATOR_OUT));

// [cmp_analog_model.sv]
`timescale 1ns/100ps
// ==========================================================================
// Behavioural analog core; voltages are plain codes
// ==========================================================================
module cmp_analog_model (
   input logic power_off,
   input logic bandgap_sel,
   input logic mux_active,
   input logic [2:0] channel,
   input logic [7:0] pos_mv,
   input logic [7:0] ref_mv,
   input logic [7:0] neg_mv,
   input logic [63:0] chan_mv,
   output logic raw
);
   logic [7:0] plus; // Positive leg level
   logic [7:0] minus; // Negative leg level
   // Positive leg: bandgap or pin
   assign plus = bandgap_sel ? ref_mv : pos_mv;
   // Negative leg: converter channel or pin
   assign minus = mux_active ? chan_mv[{channel, 3'h0} +: 8]
      : neg_mv;
   // Unpowered core reads low, which can look like a falling edge
   assign raw = !power_off && (plus > minus);
endmodule : cmp_analog_model

// [comparator_control_logic_test.sv]
`timescale 1ns/100ps
`include "cmp_regs.svh"
// ==========================================================================
// Self-checking bench
// ==========================================================================
module comparator_control_logic_test;
   logic CORE_CLK = 1'h0, SYS_RST = 1'h1;
   logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
   logic [31:0] WDATA = 32'h0, RDATA, rd_data, e;
   logic [3:0] WSTRB = 4'hf;
   logic AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0;
   logic ARVALID = 1'h0, RREADY = 1'h0;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, RAW_COMPARE, IRQ;
   logic [1:0] BRESP, RRESP, rd_resp;
   logic POWER_OFF, BANDGAP_SELECT, NEG_MUX_ACTIVE, CMP_IRQ_REQ;
   logic CAPTURE_ROUTE, CAPTURE_INPUT, COMPARATOR_OUT;
   logic [2:0] NEG_CHANNEL, CHANNEL_SELECT = 3'h0;
   logic CONVERTER_ENABLE = 1'h0, GLOBAL_IRQ_ENABLE = 1'h0;
   logic IRQ_VECTOR_ACK = 1'h0;
   logic [7:0] pos_mv = 8'h0a, neg_mv = 8'h64, ref_mv = 8'h96;
   logic [63:0] chan_mv = 64'h0;
   int failures = 0, compares = 0;
   // Mode, output direction, expected flag
   typedef struct {cmp_pkg::irq_mode_type mode; logic rise;
      logic flag;} row_type;
   row_type rows [8] = '{'{`MODE_TOGGLE, 1'h1, 1'h1},
      '{`MODE_TOGGLE, 1'h0, 1'h1}, '{`MODE_RESERVED, 1'h1, 1'h0},
      '{`MODE_RESERVED, 1'h0, 1'h0}, '{`MODE_FALL, 1'h1, 1'h0},
      '{`MODE_FALL, 1'h0, 1'h1}, '{`MODE_RISE, 1'h1, 1'h1},
      '{`MODE_RISE, 1'h0, 1'h0}};

   cmp_ctrl u_cmp_ctrl (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
      .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
      .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
      .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
      .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
      .RREADY(RREADY), .RAW_COMPARE(RAW_COMPARE), .POWER_OFF(POWER_OFF),
      .BANDGAP_SELECT(BANDGAP_SELECT), .NEG_MUX_ACTIVE(NEG_MUX_ACTIVE),
      .NEG_CHANNEL(NEG_CHANNEL), .CONVERTER_ENABLE(CONVERTER_ENABLE),
      .CHANNEL_SELECT(CHANNEL_SELECT), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
      .IRQ_VECTOR_ACK(IRQ_VECTOR_ACK), .CMP_IRQ_REQ(CMP_IRQ_REQ),
      .CAPTURE_ROUTE(CAPTURE_ROUTE), .CAPTURE_INPUT(CAPTURE_INPUT),
      .COMPARATOR_OUT(COMPARATOR_OUT), .IRQ(IRQ));
   cmp_analog_model u_cmp_analog_model (.power_off(POWER_OFF),
      .bandgap_sel(BANDGAP_SELECT), .mux_active(NEG_MUX_ACTIVE),
      .channel(NEG_CHANNEL), .pos_mv(pos_mv), .ref_mv(ref_mv),
      .neg_mv(neg_mv), .chan_mv(chan_mv), .raw(RAW_COMPARE));

   // ========================================================================
   // Clock, watchdog and closing
   // ========================================================================
   initial forever #12.5 CORE_CLK = ~CORE_CLK;
   // Run needs under a thousand cycles
   initial begin
      repeat (20000) @(posedge CORE_CLK);
      failures++;
      complete_run();
   end
   task automatic complete_run;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : complete_run

   // ========================================================================
   // Comparisons and bus tasks
   // ========================================================================
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: word %h, wanted %h", $time, got, exp);
      end
   endtask : chk_word
   task automatic chk_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: bit %b, wanted %b", $time, got, exp);
      end
   endtask : chk_bit
   // Sample mid-cycle, clear of the launching edge
   task automatic wait_n(input int n);
      repeat (n) @(negedge CORE_CLK);
   endtask : wait_n
   // Both halves offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw = 1'h0, w = 1'h0;
      @(posedge CORE_CLK);
      AWADDR <= a;
      WDATA <= d;
      {AWVALID, WVALID} <= 2'h3;
      while (!(aw && w)) begin
         @(negedge CORE_CLK);
         aw = aw | AWREADY;
         w = w | WREADY;
         @(posedge CORE_CLK);
         if (aw) AWVALID <= 1'h0;
         if (w) WVALID <= 1'h0;
      end
      BREADY <= 1'h1;
      do @(negedge CORE_CLK); while (BVALID !== 1'h1);
      chk_word({30'h0, BRESP}, {30'h0, `RESP_OKAY});
      @(posedge CORE_CLK);
      BREADY <= 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge CORE_CLK);
      ARADDR <= a;
      ARVALID <= 1'h1;
      do @(negedge CORE_CLK); while (ARREADY !== 1'h1);
      @(posedge CORE_CLK);
      ARVALID <= 1'h0;
      RREADY <= 1'h1;
      do @(negedge CORE_CLK); while (RVALID !== 1'h1);
      rd_data = RDATA;
      rd_resp = RRESP;
      @(posedge CORE_CLK);
      RREADY <= 1'h0;
   endtask : rd

   // ========================================================================
   // Main sequence
   // ========================================================================
   initial begin
      repeat (20) @(posedge CORE_CLK);
      SYS_RST <= 1'h0;
      // Reset images and an unmapped word
      rd(`OFS_SPECIAL_IO);
      chk_word(rd_data, 32'h0);
      rd(`OFS_CTRL_STATUS);
      chk_word(rd_data, 32'h0);
      rd(8'h10);
      chk_word({30'h0, rd_resp}, {30'h0, `RESP_SLVERR});
      // Each mode, both directions; flag cleared by writing one
      foreach (rows[i]) begin
         pos_mv <= rows[i].rise ? 8'h0a : 8'hc8;
         wr(`OFS_CTRL_STATUS, {28'h1, 2'h0, rows[i].mode});
         pos_mv <= rows[i].rise ? 8'hc8 : 8'h0a;
         wait_n(5);
         rd(`OFS_CTRL_STATUS);
         e = {26'h0, rows[i].rise, rows[i].flag, 2'h0, rows[i].mode};
         chk_word(rd_data, e);
      end
      // Negative input from channel 5, then the pin
      wr(`OFS_SPECIAL_IO, 32'hff);
      rd(`OFS_SPECIAL_IO);
      chk_word(rd_data, 32'hef);
      CHANNEL_SELECT <= 3'h5;
      chan_mv <= 64'h0000_1400_0000_0000;
      pos_mv <= 8'h32;
      wait_n(5);
      chk_bit(NEG_MUX_ACTIVE, 1'h1);
      chk_word({29'h0, NEG_CHANNEL}, 32'h5);
      chk_bit(COMPARATOR_OUT, 1'h1);
      @(posedge CORE_CLK);
      CONVERTER_ENABLE <= 1'h1;
      wait_n(5);
      chk_bit(NEG_MUX_ACTIVE, 1'h0);
      chk_bit(COMPARATOR_OUT, 1'h0);
      // Bandgap replaces the positive pin
      wr(`OFS_CTRL_STATUS, 32'h40);
      wait_n(5);
      chk_bit(BANDGAP_SELECT, 1'h1);
      chk_bit(COMPARATOR_OUT, 1'h1);
      // Interrupt: raised, gated, acknowledged, masked
      wr(`OFS_CTRL_STATUS, 32'h0);
      wr(`OFS_IRQ_MASK, 32'h1);
      rd(`OFS_IRQ_STATUS);
      wr(`OFS_CTRL_STATUS, 32'h18);
      pos_mv <= 8'hc8;
      wait_n(5);
      chk_bit(CMP_IRQ_REQ, 1'h0);
      chk_bit(IRQ, 1'h1);
      @(posedge CORE_CLK);
      GLOBAL_IRQ_ENABLE <= 1'h1;
      wait_n(3);
      chk_bit(CMP_IRQ_REQ, 1'h1);
      @(posedge CORE_CLK);
      IRQ_VECTOR_ACK <= 1'h1;
      @(posedge CORE_CLK);
      IRQ_VECTOR_ACK <= 1'h0;
      wait_n(3);
      chk_bit(CMP_IRQ_REQ, 1'h0);
      rd(`OFS_IRQ_STATUS);
      chk_word(rd_data, 32'h3);
      wait_n(3);
      chk_bit(IRQ, 1'h0);
      wr(`OFS_IRQ_MASK, 32'h0);
      pos_mv <= 8'h0a;
      wait_n(5);
      chk_bit(IRQ, 1'h0);
      rd(`OFS_IRQ_STATUS);
      chk_word(rd_data, 32'h5);
      // Power down with output high, irq disabled first
      wr(`OFS_CTRL_STATUS, 32'h10);
      pos_mv <= 8'hc8;
      GLOBAL_IRQ_ENABLE <= 1'h0;
      wait_n(5);
      chk_bit(COMPARATOR_OUT, 1'h1);
      wr(`OFS_CTRL_STATUS, 32'h80);
      wait_n(4);
      chk_bit(POWER_OFF, 1'h1);
      chk_bit(COMPARATOR_OUT, 1'h0);
      // Capture route follows the level, cut when off
      wr(`OFS_CTRL_STATUS, 32'h04);
      wait_n(5);
      chk_bit(CAPTURE_ROUTE, 1'h1);
      chk_bit(CAPTURE_INPUT, 1'h1);
      wr(`OFS_CTRL_STATUS, 32'h0);
      wait_n(4);
      chk_bit(CAPTURE_INPUT, 1'h0);
      complete_run();
   end
endmodule : comparator_control_logic_test
